//--- core/emr1_cfg.svh
`ifndef EMR1_CFG_SVH
`define EMR1_CFG_SVH
// AXI4-Lite register byte addresses
`define EMR1_ADDR_CFG 32'h00000000
`define EMR1_ADDR_STAT 32'h00000004
`define EMR1_ADDR_CTRL 32'h00000008
`define EMR1_ADDR_CNT 32'h0000000C
// Field positions in the captured 14-bit word
`define EMR1_BIT_DLL_DIS 0
`define EMR1_BIT_DRV_RED 1
`define EMR1_BIT_RTT_LO 2
`define EMR1_AL_LSB 3
`define EMR1_AL_MSB 5
`define EMR1_BIT_RTT_HI 6
`define EMR1_OCD_LSB 7
`define EMR1_OCD_MSB 9
`define EMR1_BIT_NDQS_DIS 10
`define EMR1_BIT_READ_STROBE_ENABLE_EN 11
`define EMR1_BIT_QOFF 12
`define EMR1_ADDR_W 14
// Codes
`define EMR1_AL_RSVD 3'h7
`define EMR1_OCD_EXIT 3'h0
`define EMR1_OCD_DEFAULT 3'h7
`define EMR1_BA_SEL 3'h1
// Control register bits
`define EMR1_CTRL_ALL_PRE 0
// DLL lock wait, in link clocks
`define EMR1_DLL_LOCK_CYC 8'd200
`define EMR1_CNT_W 8
`define EMR1_RESP_OKAY 2'h0
`define EMR1_RESP_SLVERR 2'h2
`endif

//--- core/emr1_pkg.sv
package emr1_pkg;
   typedef enum logic [1:0] {
      EMR1_RTT_OFF = 2'b00,
      EMR1_RTT_75 = 2'b01,
      EMR1_RTT_ALT = 2'b10,
      EMR1_RTT_50 = 2'b11
   } emr1_rtt_t;
   typedef enum logic [1:0] {
      EMR1_OCD_IDLE = 2'b00,
      EMR1_OCD_DFLT = 2'b01,
      EMR1_OCD_ADJ = 2'b10
   } emr1_ocd_t;
   typedef enum logic [1:0] {
      EMR1_DLL_ON = 2'b00,
      EMR1_DLL_OFF = 2'b01,
      EMR1_DLL_SREF = 2'b10
   } emr1_dll_t;
endpackage

//--- core/emr1_sync.sv
`timescale 1ns/10ps
// Two-stage level synchroniser
module emr1_sync #(
   parameter int W = 1
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] s1_q;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s1_q <= '0;
         q_out <= '0;
      end else begin
         s1_q <= d_in;
         q_out <= s1_q;
      end
   end
endmodule // emr1_sync

//--- core/emr1_top.sv
`timescale 1ns/10ps
// How it works
// - Write is CS/RAS/CAS/WE low, BA=001, value from A0-A13.
// - Rewrites accepted in operation when all banks precharged.
// - DLL turns off in self refresh and back on at exit.
// - A0 zero enables DLL, one disables it.
// - A1 zero full drive strength, one reduced.
// - A5-A3 set added_latency 0..6; 111 reserved.
// - A6,A2 select termination: off, 75, other, 50 ohm.
// - A11 selects read strobe pair; A10 floats complement strobe.
// - A9-A7 calibration program: 000 exit, 111 default.
// - A12 one disables data and strobe output buffers.
`include "emr1_cfg.svh"
module emr1_top (
   // System clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Memory command bus, link clock domain
   input wire logic link_clk_in,
   input wire logic cke_in,
   input wire logic cs_n_in,
   input wire logic ras_n_in,
   input wire logic cas_n_in,
   input wire logic we_n_in,
   input wire logic [2:0] ba_in,
   input wire logic [13:0] addr_in,
   // Decoded settings, link domain
   output logic dll_enabled_out,
   output logic drive_reduced_out,
   output logic [2:0] added_latency_out,
   output emr1_pkg::emr1_rtt_t rtt_out,
   output emr1_pkg::emr1_ocd_t driver_calibration_program_out,
   output logic read_strobe_enable_out,
   output logic dqs_n_float_out,
   output logic outputs_off_out,
   output logic read_ready_out,
   // AXI4-Lite slave
   input wire logic [31:0] awaddr_in,
   input wire logic awvalid_in,
   output logic awready_out,
   input wire logic [31:0] wdata_in,
   input wire logic [3:0] wstrb_in,
   input wire logic wvalid_in,
   output logic wready_out,
   output logic [1:0] bresp_out,
   output logic bvalid_out,
   input wire logic bready_in,
   input wire logic [31:0] araddr_in,
   input wire logic arvalid_in,
   output logic arready_out,
   output logic [31:0] rdata_out,
   output logic [1:0] rresp_out,
   output logic rvalid_out,
   input wire logic rready_in
);
   import emr1_pkg::*;

   logic [13:0] emr_q;
   logic emr_valid_q;
   logic wr_cnt_q;
   logic cke_prev_q;
   logic sref_q;
   logic [7:0] lock_cnt_q;
   logic all_pre_q;
   logic all_pre_l;
   logic mrs_hit;
   logic sref_entry;
   logic sref_exit;
   logic dll_on;
   emr1_dll_t dll_st_q;
   logic [17:0] stat_s;
   logic [31:0] rd_d;

   // Software says all banks are precharged; crosses to link domain
   emr1_sync #(.W(1)) u_pre_sync (
      .clk_in(link_clk_in),
      .rst_in(rst_in),
      .d_in(all_pre_q),
      .q_out(all_pre_l)
   );

   // Command decode on the link clock
   assign mrs_hit = cke_prev_q && cke_in && !cs_n_in && !ras_n_in &&
                    !cas_n_in && !we_n_in && (ba_in == `EMR1_BA_SEL)
                    && all_pre_l;
   assign sref_entry = cke_prev_q && !cke_in && !cs_n_in && !ras_n_in &&
                       !cas_n_in && we_n_in;
   assign sref_exit = sref_q && cke_in;

   always_ff @(posedge link_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cke_prev_q <= 1'b0;
      end else begin
         cke_prev_q <= cke_in;
      end
   end

   // Register capture; reset clears the word, the valid flag and the write toggle
   always_ff @(posedge link_clk_in or posedge rst_in) begin
      if (rst_in) begin
         emr_q <= 14'h0000;
         emr_valid_q <= 1'b0;
         wr_cnt_q <= 1'b0;
      end else if (mrs_hit) begin
         emr_q <= addr_in;
         emr_valid_q <= 1'b1;
         wr_cnt_q <= ~wr_cnt_q;
      end
   end

   // Self refresh tracking
   always_ff @(posedge link_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sref_q <= 1'b0;
      end else if (sref_entry) begin
         sref_q <= 1'b1;
      end else if (sref_exit) begin
         sref_q <= 1'b0;
      end
   end

   // DLL state
   always_ff @(posedge link_clk_in or posedge rst_in) begin
      if (rst_in) begin
         dll_st_q <= EMR1_DLL_OFF;
      end else begin
         case (dll_st_q)
            EMR1_DLL_ON: begin
               if (sref_entry) begin
                  dll_st_q <= EMR1_DLL_SREF;
               end else if (emr_q[`EMR1_BIT_DLL_DIS] || !emr_valid_q) begin
                  dll_st_q <= EMR1_DLL_OFF;
               end
            end
            EMR1_DLL_OFF: begin
               if (emr_valid_q && !emr_q[`EMR1_BIT_DLL_DIS]) begin
                  dll_st_q <= EMR1_DLL_ON;
               end
            end
            EMR1_DLL_SREF: begin
               if (sref_exit) begin
                  dll_st_q <= EMR1_DLL_ON;
               end
            end
            default: begin
               dll_st_q <= EMR1_DLL_OFF;
            end
         endcase
      end
   end
   assign dll_on = (dll_st_q == EMR1_DLL_ON);

   // Lock counter: restarts whenever the DLL is off or re-enabled
   always_ff @(posedge link_clk_in or posedge rst_in) begin
      if (rst_in) begin
         lock_cnt_q <= 8'h00;
      end else if (!dll_on || (mrs_hit && !addr_in[`EMR1_BIT_DLL_DIS])) begin
         lock_cnt_q <= 8'h00;
      end else if (lock_cnt_q != `EMR1_DLL_LOCK_CYC) begin
         lock_cnt_q <= lock_cnt_q + 8'h01;
      end
   end

   // Decoded outputs, registered
   always_ff @(posedge link_clk_in or posedge rst_in) begin
      if (rst_in) begin
         dll_enabled_out <= 1'b0;
         drive_reduced_out <= 1'b0;
         added_latency_out <= 3'h0;
         rtt_out <= EMR1_RTT_OFF;
         driver_calibration_program_out <= EMR1_OCD_IDLE;
         read_strobe_enable_out <= 1'b0;
         dqs_n_float_out <= 1'b0;
         outputs_off_out <= 1'b0;
         read_ready_out <= 1'b0;
      end else begin
         dll_enabled_out <= dll_on;
         drive_reduced_out <= emr_q[`EMR1_BIT_DRV_RED];
         // Reserved latency code held at zero
         if (emr_q[`EMR1_AL_MSB:`EMR1_AL_LSB] == `EMR1_AL_RSVD) begin
            added_latency_out <= 3'h0;
         end else begin
            added_latency_out <= emr_q[`EMR1_AL_MSB:`EMR1_AL_LSB];
         end
         rtt_out <= emr1_rtt_t'({emr_q[`EMR1_BIT_RTT_HI],
                                 emr_q[`EMR1_BIT_RTT_LO]});
         if (emr_q[`EMR1_OCD_MSB:`EMR1_OCD_LSB] == `EMR1_OCD_EXIT) begin
            driver_calibration_program_out <= EMR1_OCD_IDLE;
         end else if (emr_q[`EMR1_OCD_MSB:`EMR1_OCD_LSB] ==
                      `EMR1_OCD_DEFAULT) begin
            driver_calibration_program_out <= EMR1_OCD_DFLT;
         end else begin
            driver_calibration_program_out <= EMR1_OCD_ADJ;
         end
         read_strobe_enable_out <= emr_q[`EMR1_BIT_READ_STROBE_ENABLE_EN];
         dqs_n_float_out <= emr_q[`EMR1_BIT_NDQS_DIS];
         outputs_off_out <= emr_q[`EMR1_BIT_QOFF];
         read_ready_out <= dll_on &&
                           (lock_cnt_q == `EMR1_DLL_LOCK_CYC);
      end
   end

   // Status crossing to the system clock
   assign stat_s = {wr_cnt_q, dll_on, lock_cnt_q == `EMR1_DLL_LOCK_CYC,
                    emr_valid_q, emr_q};
   logic [17:0] stat_r;
   logic [17:0] stat_hold_q;
   logic [17:0] stat_hold_r;
   logic tog_r;
   logic tog_seen_q;
   // Handshake: capture word in link domain, toggle announces it
   logic tog_q;
   logic ack_l;
   always_ff @(posedge link_clk_in or posedge rst_in) begin
      if (rst_in) begin
         stat_hold_q <= 18'h00000;
         tog_q <= 1'b0;
      end else if (tog_q == ack_l) begin
         stat_hold_q <= stat_s;
         tog_q <= ~tog_q;
      end
   end
   emr1_sync #(.W(1)) u_tog_sync (
      .clk_in(ref_clk_in),
      .rst_in(rst_in),
      .d_in(tog_q),
      .q_out(tog_r)
   );
   emr1_sync #(.W(1)) u_ack_sync (
      .clk_in(link_clk_in),
      .rst_in(rst_in),
      .d_in(tog_seen_q),
      .q_out(ack_l)
   );
   assign stat_hold_r = stat_hold_q;
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         stat_r <= 18'h00000;
         tog_seen_q <= 1'b0;
      end else if (tog_r != tog_seen_q) begin
         stat_r <= stat_hold_r;
         tog_seen_q <= tog_r;
      end
   end

   // AXI4-Lite write channel
   logic aw_got_q;
   logic w_got_q;
   logic [31:0] awaddr_q;
   logic [31:0] wdata_q;
   logic wstrb0_q;
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= 32'h00000000;
         wdata_q <= 32'h00000000;
         awready_out <= 1'b1;
         wready_out <= 1'b1;
         bvalid_out <= 1'b0;
         bresp_out <= `EMR1_RESP_OKAY;
         all_pre_q <= 1'b0;
      end else begin
         if (awvalid_in && awready_out) begin
            aw_got_q <= 1'b1;
            awaddr_q <= awaddr_in;
            awready_out <= 1'b0;
         end
         if (wvalid_in && wready_out) begin
            w_got_q <= 1'b1;
            wdata_q <= wdata_in;
            wready_out <= 1'b0;
         end
         if (aw_got_q && w_got_q && !bvalid_out) begin
            bvalid_out <= 1'b1;
            if (awaddr_q == `EMR1_ADDR_CTRL) begin
               bresp_out <= `EMR1_RESP_OKAY;
               if (wstrb0_q) begin
                  all_pre_q <= wdata_q[`EMR1_CTRL_ALL_PRE];
               end
            end else if (awaddr_q == `EMR1_ADDR_CFG ||
                         awaddr_q == `EMR1_ADDR_STAT) begin
               bresp_out <= `EMR1_RESP_OKAY;
            end else begin
               bresp_out <= `EMR1_RESP_SLVERR;
            end
         end
         if (bvalid_out && bready_in) begin
            bvalid_out <= 1'b0;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awready_out <= 1'b1;
            wready_out <= 1'b1;
         end
      end
   end
   // Low byte lane of the accepted write
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wstrb0_q <= 1'b0;
      end else if (wvalid_in && wready_out) begin
         wstrb0_q <= wstrb_in[0];
      end
   end
   // AXI4-Lite read channel
   always_comb begin
      rd_d = 32'h00000000;
      if (araddr_in == `EMR1_ADDR_CFG) begin
         rd_d = {18'h00000, stat_r[13:0]};
      end else if (araddr_in == `EMR1_ADDR_STAT) begin
         rd_d = {28'h0000000, stat_r[17:14]};
      end else if (araddr_in == `EMR1_ADDR_CTRL) begin
         rd_d = {31'h00000000, all_pre_q};
      end
   end
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         arready_out <= 1'b1;
         rvalid_out <= 1'b0;
         rdata_out <= 32'h00000000;
         rresp_out <= `EMR1_RESP_OKAY;
      end else if (arvalid_in && arready_out) begin
         arready_out <= 1'b0;
         rvalid_out <= 1'b1;
         rdata_out <= rd_d;
         if (araddr_in == `EMR1_ADDR_CFG || araddr_in == `EMR1_ADDR_STAT
             || araddr_in == `EMR1_ADDR_CTRL) begin
            rresp_out <= `EMR1_RESP_OKAY;
         end else begin
            rresp_out <= `EMR1_RESP_SLVERR;
         end
      end else if (rvalid_out && rready_in) begin
         rvalid_out <= 1'b0;
         arready_out <= 1'b1;
      end
   end

   // Checks
   sequence s_mrs_cmd;
      mrs_hit;
   endsequence
   sequence s_capture;
      ##1 emr_q == $past(addr_in);
   endsequence
   chk_mrs_capture: assert property (@(posedge link_clk_in) disable iff (rst_in)
      s_mrs_cmd |-> s_capture) else $error("EMR1 capture wrong");
   chk_ba_select: assert property (@(posedge link_clk_in) disable iff (rst_in)
      (ba_in != `EMR1_BA_SEL) |=> $stable(emr_q)) else $error("wrong bank wrote");
   chk_dll_a0: assert property (@(posedge link_clk_in) disable iff (rst_in)
      (emr_valid_q && emr_q[`EMR1_BIT_DLL_DIS]) |-> ##2 !dll_enabled_out)
      else $error("DLL not disabled");
   chk_sref_dll: assert property (@(posedge link_clk_in) disable iff (rst_in)
      sref_q |-> !dll_on) else $error("DLL on in sref");
   chk_lock_wait: assert property (@(posedge link_clk_in) disable iff (rst_in)
      $rose(dll_on) |-> !read_ready_out[*8]) else $error("early ready");
   chk_drive_sel: assert property (@(posedge link_clk_in) disable iff (rst_in)
      ##1 drive_reduced_out == $past(emr_q[`EMR1_BIT_DRV_RED]))
      else $error("drive mismatch");
   chk_al_range: assert property (@(posedge link_clk_in) disable iff (rst_in)
      added_latency_out != `EMR1_AL_RSVD) else $error("reserved AL");
   chk_qoff_map: assert property (@(posedge link_clk_in) disable iff (rst_in)
      $rose(emr_q[`EMR1_BIT_QOFF]) |=> outputs_off_out)
      else $error("qoff late");
endmodule // emr1_top

//--- test/emr1_ctl_model.sv
`timescale 1ns/10ps
module emr1_ctl_model #(
   parameter int MRD_CYC = 2,
   // Sixteen-bit organisation has no read strobe option
   parameter logic X16 = 1'b0
) (
   // Link clock
   input wire logic link_clk_in,
   // Command bus
   output logic cke_out,
   output logic cs_n_out,
   output logic ras_n_out,
   output logic cas_n_out,
   output logic we_n_out,
   output logic [2:0] ba_out,
   output logic [13:0] addr_out
);
   logic [2:0] q_ba = 3'h0;
   logic [13:0] q_op = 14'h0;
   logic q_we = 1'h0;
   logic q_cke = 1'h1;
   int want = 0;
   int sent = 0;
   initial begin
      cke_out = 1'h1;
      cs_n_out = 1'h1;
      {ras_n_out, cas_n_out, we_n_out, ba_out, addr_out} = 20'h0;
   end
   always @(posedge link_clk_in) begin
      cke_out <= q_cke;
      cs_n_out <= (want == sent);
      if (want != sent) begin
         {ras_n_out, cas_n_out, we_n_out} <= {2'h0, q_we};
         ba_out <= q_ba;
         addr_out <= q_op;
         sent <= want;
      end else begin
         // Deselected lines keep changing
         {ras_n_out, cas_n_out, we_n_out} <= ~{ras_n_out, cas_n_out, we_n_out};
         ba_out <= ~ba_out;
         addr_out <= ~addr_out;
      end
   end
   task automatic send(input logic [2:0] b, input logic [13:0] op,
                       input logic we, input logic ck);
      @(posedge link_clk_in);
      q_ba <= b;
      q_op <= op;
      q_we <= we;
      q_cke <= ck;
      want <= want + 1;
      repeat (MRD_CYC + 1) @(posedge link_clk_in);
   endtask
   task automatic mrs(input logic [2:0] b, input logic [13:0] op);
      logic [13:0] w;
      w = {1'h0, op[12:0]};
      w[11] = w[11] & ~X16;
      send(b, w, 1'h0, 1'h1);
   endtask
   task automatic sref_enter;
      send(3'h0, 14'h0, 1'h1, 1'h0);
   endtask
   task automatic sref_exit;
      @(posedge link_clk_in);
      q_cke <= 1'h1;
      repeat (3) @(posedge link_clk_in);
   endtask
endmodule // emr1_ctl_model

//--- test/emr1_top_tb.sv
`timescale 1ns/10ps
`include "emr1_cfg.svh"
module emr1_top_tb;
   import emr1_pkg::*;
   logic clk = 1'h0;
   logic lclk = 1'h0;
   logic rst = 1'h1;
   logic cke, cs_n, ras_n, cas_n, we_n, dll, drv, rse, dqsf, qoff, rdy;
   logic [2:0] ba, al;
   logic [13:0] addr;
   emr1_rtt_t rtt;
   emr1_ocd_t driver_calibration_program;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, d;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, r;
   int fail_count = 0;
   int comparisons = 0;
   always #5 clk = ~clk;
   initial begin
      #7;
      forever #15 lclk = ~lclk;
   end
   emr1_top i_emr1_top (
      .ref_clk_in(clk), .rst_in(rst), .link_clk_in(lclk), .cke_in(cke),
      .cs_n_in(cs_n), .ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n),
      .ba_in(ba), .addr_in(addr), .dll_enabled_out(dll),
      .drive_reduced_out(drv), .added_latency_out(al), .rtt_out(rtt),
      .driver_calibration_program_out(driver_calibration_program), .read_strobe_enable_out(rse),
      .dqs_n_float_out(dqsf), .outputs_off_out(qoff), .read_ready_out(rdy),
      .awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready),
      .wdata_in(wdata), .wstrb_in(4'hF), .wvalid_in(wvalid),
      .wready_out(wready), .bresp_out(bresp), .bvalid_out(bvalid),
      .bready_in(bready), .araddr_in(araddr), .arvalid_in(arvalid),
      .arready_out(arready), .rdata_out(rdata), .rresp_out(rresp),
      .rvalid_out(rvalid), .rready_in(rready)
   );
   emr1_ctl_model i_emr1_ctl_model (
      .link_clk_in(lclk), .cke_out(cke), .cs_n_out(cs_n),
      .ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n),
      .ba_out(ba), .addr_out(addr)
   );
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      if (fail_count == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic hang;
      fail_count++;
      test_done();
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      int n;
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         if (bvalid) break;
      end
      if (n == 50) hang();
      r = bresp;
      bready <= 1'h0;
   endtask
   task automatic rd(input logic [31:0] a);
      int n;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'h0;
         if (rvalid) break;
      end
      if (n == 50) hang();
      d = rdata;
      r = rresp;
      rready <= 1'h0;
   endtask
   task automatic lw(input int n);
      repeat (n) @(posedge lclk);
   endtask
   task automatic fields(input logic [13:0] op);
      rd(`EMR1_ADDR_CFG);
      chk(d, {18'h0, op});
      chk(dll, !op[0]);
      chk(drv, op[1]);
      chk(al, (op[5:3] == 3'h7) ? 3'h0 : op[5:3]);
      chk(rtt, {op[6], op[2]});
      chk(rse, op[11]);
      chk(dqsf, op[10]);
      chk(driver_calibration_program, (op[9:7] == 3'h0) ? EMR1_OCD_IDLE :
          ((op[9:7] == 3'h7) ? EMR1_OCD_DFLT : EMR1_OCD_ADJ));
      chk(qoff, op[12]);
   endtask
   task automatic t_reset;
      chk(dll, 1'h0);
      chk(rdy, 1'h0);
      rd(`EMR1_ADDR_STAT);
      chk(d[0], 1'h0);
      rd(`EMR1_ADDR_CTRL);
      chk(d, 32'h0);
   endtask
   task automatic t_refused;
      i_emr1_ctl_model.mrs(3'h1, 14'h0002);
      lw(10);
      chk(drv, 1'h0);
      rd(`EMR1_ADDR_STAT);
      chk(d[0], 1'h0);
   endtask
   task automatic t_fields;
      logic [2:0] v;
      logic [13:0] op;
      wr(`EMR1_ADDR_CTRL, 32'h1);
      rd(`EMR1_ADDR_CTRL);
      chk(d, 32'h1);
      lw(6);
      for (int i = 0; i < 8; i++) begin
         v = i[2:0];
         op = {1'h0, v[0], v[1], v[2], v, v[1], v, v[0], v[1], v[2]};
         i_emr1_ctl_model.mrs(3'h1, op);
         // Other register selects right after must not land
         i_emr1_ctl_model.mrs((v == 3'h1) ? 3'h0 : v, ~op);
         lw(12);
         fields(op);
      end
      rd(`EMR1_ADDR_STAT);
      chk(d[0], 1'h1);
   endtask
   task automatic t_lock;
      int n;
      i_emr1_ctl_model.mrs(3'h1, 14'h0);
      lw(170);
      chk(rdy, 1'h0);
      for (n = 0; n < 80 && rdy !== 1'h1; n++) lw(1);
      chk(rdy, 1'h1);
      chk(driver_calibration_program, EMR1_OCD_IDLE);
      lw(10);
      rd(`EMR1_ADDR_STAT);
      chk(d[2:0], 3'h7);
   endtask
   task automatic t_sref;
      i_emr1_ctl_model.sref_enter();
      lw(4);
      chk(dll, 1'h0);
      i_emr1_ctl_model.sref_exit();
      lw(4);
      chk(dll, 1'h1);
   endtask
   task automatic t_bus;
      wr(32'h10, 32'h0);
      chk(r, `EMR1_RESP_SLVERR);
      rd(32'h10);
      chk(r, `EMR1_RESP_SLVERR);
      wr(`EMR1_ADDR_CFG, 32'h3FFF);
      rd(`EMR1_ADDR_CFG);
      chk(d, 32'h0);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'h0;
      t_reset();
      t_refused();
      t_fields();
      t_lock();
      t_sref();
      t_bus();
      test_done();
   end
endmodule // emr1_top_tb
